// ---- rtl/afc_pkg.sv ----
// Constants, types and helpers for the host controller of the 2048 x 9 strobe FIFO.
// Function
// - Host resets the device before any write.
// - Strobes high before reset release, then recover.
// - Host triggers rewind by pulsing it low.
// - Read strobe high around rewind release.
package afc_pkg;

   // Device word width.
   localparam int WORD_W = 9;

   // Register offsets (byte addresses, one aligned word each).
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_WDATA  = 4'h4;
   localparam logic [3:0] OFS_RDATA  = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;

   // Control register fields: one-shot commands and static pin levels.
   localparam int CTRL_WRITE   = 0;
   localparam int CTRL_READ    = 1;
   localparam int CTRL_CLEAR   = 2;
   localparam int CTRL_REWIND  = 3;
   localparam int CTRL_HEAD_N  = 8;
   localparam int CTRL_CHAIN_N = 9;

   // Status register fields.
   localparam int ST_BUSY    = 0;
   localparam int ST_READY   = 1;
   localparam int ST_SPACE   = 2;
   localparam int ST_DATA    = 3;
   localparam int ST_HALF    = 4;
   localparam int ST_REFUSED = 5;
   localparam int ST_DROPPED = 6;
   localparam int ST_RVALID  = 7;

   // Reset value of the static pin levels: single device, no chaining.
   localparam logic CTRL_HEAD_RST  = 1'b1;
   localparam logic CTRL_CHAIN_RST = 1'b0;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Clock period and device timing in ns, slowest-safe figures of the fastest grade.
   localparam int CLK_NS      = 10;
   localparam int T_WPW_NS    = 50;
   localparam int T_WR_NS     = 15;
   localparam int T_DS_NS     = 30;
   localparam int T_RPW_NS    = 50;
   localparam int T_ACC_NS    = 50;
   localparam int T_RR_NS     = 15;
   localparam int T_RS_NS     = 50;
   localparam int T_RSR_NS    = 15;
   localparam int T_RT_NS     = 50;
   localparam int T_RTR_NS    = 15;
   localparam int T_FFW_NS    = 10;

   // Least time to whole cycles, rounded up, never below one.
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [3:0] WR_LOW_CYC  = 4'(cyc_up((T_WPW_NS > T_DS_NS) ? T_WPW_NS : T_DS_NS));
   localparam logic [3:0] WR_REC_CYC  = 4'(cyc_up(T_WR_NS));
   // One extra cycle so the sampled data is past the access time.
   localparam logic [3:0] RD_LOW_CYC  = 4'(cyc_up((T_RPW_NS > T_ACC_NS) ? T_RPW_NS : T_ACC_NS)
                                            + 1);
   localparam logic [3:0] RD_REC_CYC  = 4'(cyc_up(T_RR_NS));
   localparam logic [3:0] RS_LOW_CYC  = 4'(cyc_up(T_RS_NS));
   localparam logic [3:0] RS_REC_CYC  = 4'(cyc_up(T_RSR_NS));
   localparam logic [3:0] RT_LOW_CYC  = 4'(cyc_up(T_RT_NS));
   localparam logic [3:0] RT_REC_CYC  = 4'(cyc_up(T_RTR_NS));
   localparam logic [3:0] FLAG_SETTLE_CYC = 4'(cyc_up(T_FFW_NS));

   // Sequencer states, Gray steps from low phase to recovery on each access path.
   typedef enum logic [3:0] {
      S_IDLE   = 4'h0,
      S_W_LOW  = 4'h1,
      S_W_REC  = 4'h3,
      S_R_LOW  = 4'h2,
      S_R_REC  = 4'h6,
      S_RS_LOW = 4'h4,
      S_RS_REC = 4'h5,
      S_RT_LOW = 4'hc,
      S_RT_REC = 4'hd
   } afc_state_t;

endpackage

// ---- rtl/afc_host.sv ----
// Host controller that drives the strobe FIFO pins from AXI4-Lite commands.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module afc_host import afc_pkg::*; (
   input  wire logic              aclk,                    // System clock, 100 MHz.
   input  wire logic              aresetn,                 // Synchronous reset, active low.
   input  wire logic [3:0]        s_axi_awaddr,            // Write address.
   input  wire logic              s_axi_awvalid,           // Write address valid.
   output logic                   s_axi_awready,           // Write address ready.
   input  wire logic [31:0]       s_axi_wdata,             // Write data.
   input  wire logic [3:0]        s_axi_wstrb,             // Write byte strobes.
   input  wire logic              s_axi_wvalid,            // Write data valid.
   output logic                   s_axi_wready,            // Write data ready.
   output logic [1:0]             s_axi_bresp,             // Write response.
   output logic                   s_axi_bvalid,            // Write response valid.
   input  wire logic              s_axi_bready,            // Write response ready.
   input  wire logic [3:0]        s_axi_araddr,            // Read address.
   input  wire logic              s_axi_arvalid,           // Read address valid.
   output logic                   s_axi_arready,           // Read address ready.
   output logic [31:0]            s_axi_rdata,             // Read data.
   output logic [1:0]             s_axi_rresp,             // Read response.
   output logic                   s_axi_rvalid,            // Read data valid.
   input  wire logic              s_axi_rready,            // Read data ready.
   output logic                   fifo_clear_n,            // Device reset, active low.
   output logic                   fifo_write_n,            // Write strobe, active low.
   output logic                   fifo_read_n,             // Read strobe, active low.
   output logic                   first_load_or_rewind_n,  // Head select at reset, else rewind.
   output logic                   chain_enable_in_n,       // Expansion input level.
   output logic [WORD_W-1:0]      fifo_data_in,            // Data to the device.
   input  wire logic [WORD_W-1:0] fifo_data_out,           // Data from the device.
   input  wire logic              no_space_flag_n,         // Device full, active low.
   input  wire logic              no_data_flag_n,          // Device empty, active low.
   input  wire logic              chain_out_or_halfway_n   // Halfway flag, active low.
);

   afc_state_t          state_reg, state_next;
   logic [3:0]          cnt_reg;
   logic [3:0]          space_ok_cnt_reg;
   logic                ready_reg;
   logic                head_n_reg, chain_n_reg;
   logic [3:0]          cmd_reg;
   logic [WORD_W-1:0]   wdata_reg, rcap_reg;
   logic                refused_reg, dropped_reg, rvalid_reg;
   logic                full_sync_reg, empty_sync_reg, half_sync_reg;
   logic                aw_have_reg, w_have_reg;
   logic [3:0]          aw_addr_reg;
   logic [31:0]         w_data_reg;
   logic [3:0]          w_strb_reg;

   // Decode of the buffered write and of the read address.
   wire        do_write    = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire        wr_ctrl     = do_write && (aw_addr_reg == OFS_CTRL);
   wire        wr_wdata    = do_write && (aw_addr_reg == OFS_WDATA);
   wire        wr_status   = do_write && (aw_addr_reg == OFS_STATUS);
   wire        wr_known    = wr_ctrl || wr_wdata || wr_status;
   wire        rd_take     = s_axi_arvalid && s_axi_arready;
   wire        rd_known    = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_WDATA) ||
                             (s_axi_araddr == OFS_RDATA) || (s_axi_araddr == OFS_STATUS);
   wire        idle        = (state_reg == S_IDLE);
   wire        step_done   = (state_reg == S_W_LOW  && cnt_reg == WR_LOW_CYC - 4'h1) ||
                             (state_reg == S_W_REC  && cnt_reg == WR_REC_CYC - 4'h1) ||
                             (state_reg == S_R_LOW  && cnt_reg == RD_LOW_CYC - 4'h1) ||
                             (state_reg == S_R_REC  && cnt_reg == RD_REC_CYC - 4'h1) ||
                             (state_reg == S_RS_LOW && cnt_reg == RS_LOW_CYC - 4'h1) ||
                             (state_reg == S_RS_REC && cnt_reg == RS_REC_CYC - 4'h1) ||
                             (state_reg == S_RT_LOW && cnt_reg == RT_LOW_CYC - 4'h1) ||
                             (state_reg == S_RT_REC && cnt_reg == RT_REC_CYC - 4'h1);
   // Full is trusted released only after it has stood high long enough.
   wire        space_ok    = full_sync_reg && (space_ok_cnt_reg >= FLAG_SETTLE_CYC);
   wire        data_ok     = empty_sync_reg;
   // Writes are held back until the device has seen its first reset.
   wire        go_write    = idle && ready_reg && cmd_reg[CTRL_WRITE] && !cmd_reg[CTRL_CLEAR];
   wire        go_read     = idle && ready_reg && cmd_reg[CTRL_READ] && !cmd_reg[CTRL_WRITE];
   wire        refuse_now  = (go_write && !space_ok) || (go_read && !data_ok);
   wire [31:0] status_word = {24'h000000, rvalid_reg, dropped_reg, refused_reg, half_sync_reg,
                              empty_sync_reg, full_sync_reg, ready_reg, !idle};
   wire [31:0] ctrl_word   = {22'h000000, chain_n_reg, head_n_reg, 4'h0, cmd_reg};

   // Sequencer: clear has priority, then rewind, write, read.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (cmd_reg[CTRL_CLEAR] || !ready_reg)
               state_next = S_RS_LOW;
            else if (cmd_reg[CTRL_REWIND])
               state_next = S_RT_LOW;
            else if (go_write && space_ok)
               state_next = S_W_LOW;
            else if (go_read && data_ok)
               state_next = S_R_LOW;
         end
         S_W_LOW:  if (step_done) state_next = S_W_REC;
         S_W_REC:  if (step_done) state_next = S_IDLE;
         S_R_LOW:  if (step_done) state_next = S_R_REC;
         S_R_REC:  if (step_done) state_next = S_IDLE;
         S_RS_LOW: if (step_done) state_next = S_RS_REC;
         S_RS_REC: if (step_done) state_next = S_IDLE;
         S_RT_LOW: if (step_done) state_next = S_RT_REC;
         S_RT_REC: if (step_done) state_next = S_IDLE;
         default:  state_next = S_IDLE;
      endcase
   end

   // State and phase counter. Reset leaves the sequencer idle, so the power-up clear enters
   // its low phase with a fresh count and keeps the full pulse width.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= S_IDLE;
         cnt_reg   <= 4'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= (state_next != state_reg) ? 4'h0 : cnt_reg + 4'h1;
      end
   end

   // Pin drivers, all from flops. Strobes stay high through reset and its recovery.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fifo_clear_n           <= 1'b1;
         fifo_write_n           <= 1'b1;
         fifo_read_n            <= 1'b1;
         first_load_or_rewind_n <= 1'b1;
         chain_enable_in_n      <= 1'b0;
      end else begin
         fifo_clear_n           <= !(state_next == S_RS_LOW);
         fifo_write_n           <= !(state_next == S_W_LOW);
         fifo_read_n            <= !(state_next == S_R_LOW);
         // Head select is shown during reset; outside it the pin is the rewind strobe.
         // Read strobe is already high and stays so through recovery.
         first_load_or_rewind_n <= (state_next == S_RT_LOW) ? 1'b0 :
                                   (state_next == S_RS_LOW) ? head_n_reg : 1'b1;
         chain_enable_in_n      <= chain_n_reg;
      end
   end

   // Power-up reset bookkeeping and device flag sampling.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_reg        <= 1'b0;
         full_sync_reg    <= 1'b0;
         empty_sync_reg   <= 1'b0;
         half_sync_reg    <= 1'b1;
         space_ok_cnt_reg <= 4'h0;
      end else begin
         if (state_reg == S_RS_REC && step_done)
            ready_reg <= 1'b1;
         full_sync_reg    <= no_space_flag_n;
         empty_sync_reg   <= no_data_flag_n;
         half_sync_reg    <= chain_out_or_halfway_n;
         if (!full_sync_reg)
            space_ok_cnt_reg <= 4'h0;
         else if (space_ok_cnt_reg != FLAG_SETTLE_CYC)
            space_ok_cnt_reg <= space_ok_cnt_reg + 4'h1;
      end
   end

   // Pending commands and static levels. A command written while busy is dropped.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_reg     <= 4'h0;
         head_n_reg  <= CTRL_HEAD_RST;
         chain_n_reg <= CTRL_CHAIN_RST;
         wdata_reg   <= '0;
      end else begin
         if (wr_ctrl && w_strb_reg[0] && idle && cmd_reg == 4'h0)
            cmd_reg <= w_data_reg[3:0];
         else if (idle && state_next != S_IDLE)
            cmd_reg <= 4'h0;
         else if (refuse_now)
            cmd_reg <= 4'h0;
         if (wr_ctrl && w_strb_reg[1]) begin
            head_n_reg  <= w_data_reg[CTRL_HEAD_N];
            chain_n_reg <= w_data_reg[CTRL_CHAIN_N];
         end
         if (wr_wdata && idle) begin
            if (w_strb_reg[0]) wdata_reg[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) wdata_reg[8]   <= w_data_reg[8];
         end
      end
   end
   assign fifo_data_in = wdata_reg;

   // Read capture and sticky status; a set in the clearing cycle wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rcap_reg    <= '0;
         rvalid_reg  <= 1'b0;
         refused_reg <= 1'b0;
         dropped_reg <= 1'b0;
      end else begin
         if (state_reg == S_R_LOW && step_done) begin
            rcap_reg   <= fifo_data_out;
            rvalid_reg <= 1'b1;
         end else if (rd_take && s_axi_araddr == OFS_RDATA) begin
            rvalid_reg <= 1'b0;
         end
         refused_reg <= refuse_now ||
                        (refused_reg && !(wr_status && w_data_reg[ST_REFUSED]));
         dropped_reg <= (wr_ctrl && (!idle || cmd_reg != 4'h0)) ||
                        (dropped_reg && !(wr_status && w_data_reg[ST_DROPPED]));
      end
   end

   // AXI write side: address and data are taken in either order, response after both.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         aw_addr_reg   <= 4'h0;
         w_data_reg    <= 32'h00000000;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
         end else if (do_write) begin
            aw_have_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_have_reg <= 1'b0;
         end
         s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read side: one read at a time, answered the cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_take;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
               OFS_CTRL:   s_axi_rdata <= ctrl_word;
               OFS_WDATA:  s_axi_rdata <= {23'h000000, wdata_reg};
               OFS_RDATA:  s_axi_rdata <= {23'h000000, rcap_reg};
               OFS_STATUS: s_axi_rdata <= status_word;
               default:    s_axi_rdata <= 32'h00000000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// ---- tb/afc_host_asserts.sv ----
// Checker for the pin side of the strobe FIFO host controller.
`timescale 1ns/1ns
module afc_host_asserts import afc_pkg::*; (
   input wire logic              aclk,                    // Clock.
   input wire logic              aresetn,                 // Reset, active low.
   input wire logic              fifo_clear_n,            // Device reset.
   input wire logic              fifo_write_n,            // Write strobe.
   input wire logic              fifo_read_n,             // Read strobe.
   input wire logic              first_load_or_rewind_n,  // Rewind pin.
   input wire logic [WORD_W-1:0] fifo_data_in,            // Data to the device.
   input wire logic              no_space_flag_n,         // Full flag.
   input wire logic              no_data_flag_n           // Empty flag.
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Pulse shapes; a short pulse would break the device's minimum widths.
   sequence s_wr_pulse;
      (!fifo_write_n) [*5] ##1 fifo_write_n;
   endsequence
   sequence s_rd_pulse;
      (!fifo_read_n) [*6] ##1 fifo_read_n;
   endsequence
   sequence s_rewind;
      (!first_load_or_rewind_n && fifo_read_n) [*5]
      ##1 (first_load_or_rewind_n && fifo_read_n) [*2];
   endsequence
   sequence s_rewind_start;
      $fell(first_load_or_rewind_n) && fifo_clear_n;
   endsequence
   sequence s_clear_pulse;
      (!fifo_clear_n) [*5] ##1 fifo_clear_n;
   endsequence
   sequence s_clear_recover;
      ($past(fifo_write_n && fifo_read_n) && fifo_write_n && fifo_read_n)
      ##1 (fifo_write_n && fifo_read_n);
   endsequence
   a_write_pulse_len: assert property ($fell(fifo_write_n) |-> s_wr_pulse)
      else $error("write strobe pulse has the wrong length");
   a_read_pulse_len: assert property ($fell(fifo_read_n) |-> s_rd_pulse)
      else $error("read strobe pulse has the wrong length");
   a_write_not_full: assert property ($fell(fifo_write_n) |-> $past(no_space_flag_n))
      else $error("write strobe started while full");
   a_read_not_empty: assert property ($fell(fifo_read_n) |-> $past(no_data_flag_n))
      else $error("read strobe started while empty");
   a_data_held: assert property (!fifo_write_n |=> $stable(fifo_data_in))
      else $error("write data moved around the strobe");
   a_clear_width: assert property ($fell(fifo_clear_n) |-> s_clear_pulse)
      else $error("device reset pulse has the wrong length");
   a_clear_recover: assert property ($rose(fifo_clear_n) |-> s_clear_recover)
      else $error("strobe near reset");
   a_rewind_shape: assert property (s_rewind_start |-> s_rewind)
      else $error("rewind pulse or read strobe wrong");
   a_powerup_clear: assert property ($rose(aresetn) |-> ##[1:3] !fifo_clear_n)
      else $error("no device reset after power-up");
endmodule
bind afc_host afc_host_asserts i_chk (.aclk, .aresetn, .fifo_clear_n, .fifo_write_n, .fifo_read_n,
   .first_load_or_rewind_n, .fifo_data_in, .no_space_flag_n, .no_data_flag_n);

// ---- tb/afc_fifo_model.sv ----
// Behavioural model of the 2048 x 9 strobe FIFO driven by the host.
`timescale 1ns/1ns
module afc_fifo_model import afc_pkg::*; #(
   parameter int DLY = 5  // Settle delay of flags and data in ns.
) (
   input  wire logic              fifo_clear_n,            // Device reset.
   input  wire logic              fifo_write_n,            // Write strobe.
   input  wire logic              fifo_read_n,             // Read strobe.
   input  wire logic              first_load_or_rewind_n,  // Rewind pulse.
   input  wire logic              chain_enable_in_n,       // Expansion input.
   input  wire logic [WORD_W-1:0] fifo_data_in,            // Data in.
   output logic [WORD_W-1:0]      fifo_data_out,           // Data out.
   output logic                   no_space_flag_n,         // Full, active low.
   output logic                   no_data_flag_n,          // Empty, active low.
   output logic                   chain_out_or_halfway_n   // Halfway, active low.
);
   logic [WORD_W-1:0] mem [2048];
   logic [10:0]       wp = 11'h0;
   logic [10:0]       rp = 11'h0;
   logic [11:0]       cnt = 12'h3;  // Not empty at power-up, so a missing clear shows.
   logic              wr_ok = 1'b0;
   logic              rd_ok = 1'b0;
   logic [WORD_W-1:0] dq = 9'h0aa;
   // Flags follow the pointer distance only; halfway works in single mode only.
   assign #DLY no_space_flag_n = (cnt != 12'h800);
   assign #DLY no_data_flag_n = (cnt != 12'h000);
   // In chained mode the pin pulses low while the last location is written or read.
   // A chained tail waiting for chain pulses lies outside single mode and is not modelled.
   assign #DLY chain_out_or_halfway_n = chain_enable_in_n ?
      !((wr_ok && wp == 11'h7ff) || (rd_ok && rp == 11'h7ff)) : (cnt <= 12'h400);
   assign #DLY fifo_data_out = dq;
   // Reset puts both pointers at the first location.
   always @(negedge fifo_clear_n) begin
      wp = 11'h0;
      rp = 11'h0;
      cnt = 12'h0;
   end
   // A write is judged on the count at its falling edge, stored at its rising edge.
   always @(negedge fifo_write_n) wr_ok = fifo_clear_n && (cnt != 12'h800);
   always @(posedge fifo_write_n) begin
      if (wr_ok) begin
         mem[wp] = fifo_data_in;
         wp = wp + 11'h1;
         cnt = cnt + 12'h1;
      end
      wr_ok = 1'b0;
   end
   // Outside a read the bus shows the inverse of the last word, never a held one.
   always @(negedge fifo_read_n) begin
      rd_ok = fifo_clear_n && (cnt != 12'h0);
      dq = rd_ok ? mem[rp] : ~dq;
   end
   always @(posedge fifo_read_n) begin
      if (rd_ok) begin
         rp = rp + 11'h1;
         cnt = cnt - 12'h1;
      end
      rd_ok = 1'b0;
      dq = ~dq;
   end
   // Rewind acts as the pulse ends and moves only the read pointer.
   always @(posedge first_load_or_rewind_n) begin
      if (fifo_clear_n) begin
         rp = 11'h0;
         cnt = {1'b0, wp};
      end
   end
endmodule

// ---- tb/tb_afc_host.sv ----
// Self-checking bench for the strobe FIFO host controller.
`timescale 1ns/1ns
module tb_afc_host import afc_pkg::*;;
   logic              aclk = 1'b0, aresetn = 1'b0;
   logic [3:0]        s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, st, d;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              fifo_clear_n, fifo_write_n, fifo_read_n, first_load_or_rewind_n;
   logic              chain_enable_in_n, no_space_flag_n, no_data_flag_n, chain_out_or_halfway_n;
   logic [WORD_W-1:0] fifo_data_in, fifo_data_out;
   logic [8:0]        pat [3] = '{9'h1a5, 9'h05a, 9'h100};
   int                error_cnt = 0, n_checks = 0;
   afc_host i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .fifo_clear_n, .fifo_write_n, .fifo_read_n, .first_load_or_rewind_n,
      .chain_enable_in_n, .fifo_data_in, .fifo_data_out, .no_space_flag_n, .no_data_flag_n,
      .chain_out_or_halfway_n);
   afc_fifo_model i_dev (.fifo_clear_n, .fifo_write_n, .fifo_read_n, .first_load_or_rewind_n,
      .chain_enable_in_n, .fifo_data_in, .fifo_data_out, .no_space_flag_n, .no_data_flag_n,
      .chain_out_or_halfway_n);
   initial forever #5 aclk = ~aclk;
   // The fill of 2048 words takes about 35k cycles; the limit stays under 100k cycles.
   initial begin
      #800000;
      error_cnt++;
      complete_run();
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Address and data offered together; each is released once its ready is seen.
   task automatic axw(input logic [3:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] a, output logic [31:0] v);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   // Commands keep the head select level high, then wait for the sequencer to idle.
   task automatic cmd(input logic [3:0] c);
      axw(OFS_CTRL, {22'h0, 2'b01, 4'h0, c});
      do axr(OFS_STATUS, st); while (st[ST_BUSY] !== 1'b0);
   endtask
   // Status bits 6..2 are dropped, refused, halfway_n, data present and space left.
   task automatic sts(input logic [4:0] e);
      axr(OFS_STATUS, st);
      chk({27'h0, st[6:2]}, {27'h0, e});
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      do axr(OFS_STATUS, st); while (st[ST_READY] !== 1'b1);
      sts(5'b00101);
      cmd(4'h2);
      sts(5'b01101);
      axw(OFS_STATUS, 32'h60);
      for (int i = 0; i < 3; i++) begin
         axw(OFS_WDATA, {23'h0, pat[i]});
         cmd(4'h1);
      end
      sts(5'b00111);
      // Second pass reads the same words again after the rewind.
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 3; i++) begin
            cmd(4'h2);
            axr(OFS_RDATA, d);
            chk({23'h0, d[8:0]}, {23'h0, pat[i]});
         end
         sts(5'b00101);
         cmd(4'h8);
      end
      // A command written while the clear runs is dropped and flagged.
      axw(OFS_CTRL, {22'h0, 2'b01, 4'h0, 4'h4});
      cmd(4'h8);
      sts(5'b10101);
      axw(OFS_STATUS, 32'h60);
      cmd(4'h4);
      sts(5'b00101);
      for (int i = 0; i < 2048; i++) begin
         axw(OFS_WDATA, {23'h0, i[8:0]});
         cmd(4'h1);
         if (i == 1023) sts(5'b00111);
         if (i == 1024) sts(5'b00011);
      end
      sts(5'b00010);
      axw(OFS_WDATA, 32'h1ee);
      cmd(4'h1);
      sts(5'b01010);
      axw(OFS_STATUS, 32'h60);
      cmd(4'h2);
      axr(OFS_RDATA, d);
      chk({23'h0, d[8:0]}, 32'h0);
      sts(5'b00011);
      cmd(4'h1);
      sts(5'b00010);
      complete_run();
   end
endmodule
